// ---- tb_top.sv ----
// self-checking bench for the controller enable and status slice
`timescale 1ns/1ns
module tb_top;
    logic                 ref_clk_i = 1'b0;
    logic                 rstn_i = 1'b0;
    logic [31:0]          addr_i = 32'h0;
    logic [15:0]          wdata_i = 16'h0;
    logic                 wr_i = 1'b0;
    logic                 rd_i = 1'b0;
    logic [15:0]          rdata_o;
    twc_pkg::twc_engine_t eng;
    twc_pkg::twc_ctl_t    ctl_o;
    logic                 irq_o;
    logic [5:0]           tx_lvl;
    logic [5:0]           rx_lvl;
    logic [2:0]           busy = 3'h0;
    logic [1:0]           ev = 2'h0;
    logic [5:0]           tx_f = 6'h00;
    logic [5:0]           rx_f = 6'h00;
    logic [31:0]          lfsr = 32'h0001681E;
    logic [15:0]          got;
    int                   mismatches = 0;
    int                   samples_checked = 0;
    int                   cycles = 0;

    always #50 ref_clk_i = ~ref_clk_i;

    twc_ctrl dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .eng_i(eng), .tx_level_i(tx_lvl), .rx_level_i(rx_lvl),
        .ctl_o(ctl_o), .irq_o(irq_o));
    twc_bus_model far (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ctl_i(ctl_o),
        .busy_i(busy), .start_i(ev[0]), .bcast_i(ev[1]), .tx_fill_i(tx_f),
        .rx_fill_i(rx_f), .eng_o(eng), .tx_level_o(tx_lvl),
        .rx_level_o(rx_lvl));

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done

    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : idle

    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        // one quiet edge keeps a following strobe from a double assignment
        @(posedge ref_clk_i);
    endtask : wr

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [31:0] a, output logic [15:0] d);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
        @(posedge ref_clk_i);
    endtask : rd

    task automatic pulse(input logic [1:0] e);
        ev <= e;
        @(posedge ref_clk_i);
        ev <= 2'h0;
        idle(6);
    endtask : pulse

    function automatic logic [15:0] exp_st();
        int t = tx_lvl;
        int r = rx_lvl;
        return {9'h000, eng.target_fsm_busy, eng.initiator_fsm_busy,
            r == twc_pkg::FIFO_DEPTH, r > 0, t == 0,
            t < twc_pkg::FIFO_DEPTH, |busy};
    endfunction : exp_st

    initial begin
        idle(10);
        rstn_i <= 1'b1;
        idle(2);
        rd(twc_pkg::CONTROLLER_STATUS_OFS, got);
        check(got, twc_pkg::STATUS_RST);
        rd(twc_pkg::CONTROLLER_ENABLE_OFS, got);
        check(got, 16'h0000);
        check({ctl_o.tx_flush, ctl_o.rx_flush}, 16'h0003);
        wr(twc_pkg::CONTROLLER_ENABLE_OFS, 16'hFFFF);
        idle(1);
        #1 check(ctl_o.ctrl_en, 16'h0000);
        @(posedge ref_clk_i);
        #1 check({ctl_o.ctrl_en, ctl_o.tx_flush}, 16'h0002);
        @(posedge ref_clk_i);
        rd(twc_pkg::CONTROLLER_ENABLE_OFS, got);
        check(got, 16'h0001);
        for (int i = 0; i < 12; i++) begin
            lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
            busy <= lfsr[2:0];
            tx_f <= (i % 3 == 0) ? 6'h20 : {1'b0, lfsr[8:4]};
            rx_f <= (i % 4 == 1) ? 6'h20 : {1'b0, lfsr[13:9]};
            idle(6);
            rd(twc_pkg::CONTROLLER_STATUS_OFS, got);
            check(got, exp_st());
        end
        busy <= 3'h0;
        for (int k = 0; k < 2; k++) begin
            pulse(k == 0 ? 2'h1 : 2'h2);
            rd(twc_pkg::RAW_IRQ_FLAGS_OFS, got);
            check(got[11:10], k == 0 ? 16'h0001 : 16'h0002);
            rd(k == 0 ? twc_pkg::START_DETECT_CLEAR_OFS
                      : twc_pkg::GENERAL_CALL_CLEAR_OFS, got);
            check(got, 16'h0000);
            rd(twc_pkg::RAW_IRQ_FLAGS_OFS, got);
            check(got[11:10], 16'h0000);
        end
        wr(twc_pkg::IRQ_STATUS_OFS, 16'h0007);
        wr(twc_pkg::IRQ_MASK_OFS, 16'h0001);
        pulse(2'h1);
        check(irq_o, 16'h0001);
        wr(twc_pkg::IRQ_MASK_OFS, 16'h0000);
        idle(2);
        check(irq_o, 16'h0000);
        wr(twc_pkg::IRQ_STATUS_OFS, 16'h0001);
        wr(twc_pkg::IRQ_MASK_OFS, 16'h0001);
        idle(2);
        check(irq_o, 16'h0000);
        rd(32'h50001490, got);
        check(got, 16'h0000);
        busy <= 3'h3;
        idle(6);
        // disable mid transfer, then check the stop requests while the engine stays busy
        wr(twc_pkg::CONTROLLER_ENABLE_OFS, 16'h0000);
        idle(6);
        check({ctl_o.ctrl_en, ctl_o.tx_flush, ctl_o.rx_flush}, 16'h0003);
        check(ctl_o.stop_after_xfer, 16'h0001);
        check(ctl_o.nack_stop, 16'h0001);
        wr(twc_pkg::CONTROLLER_STATUS_OFS, 16'hFFFF);
        rd(twc_pkg::CONTROLLER_STATUS_OFS, got);
        check(got, exp_st());
        // a clear read while still busy must not drop activity
        rd(twc_pkg::ACTIVITY_CLEAR_OFS, got);
        rd(twc_pkg::RAW_IRQ_FLAGS_OFS, got);
        check(got[8], 16'h0001);
        busy <= 3'h0;
        idle(6);
        rd(twc_pkg::RAW_IRQ_FLAGS_OFS, got);
        check(got[8], 16'h0000);
        test_done();
    end
endmodule : tb_top

// ---- twc_bus_model.sv ----
// far side model: protocol engine flags and fifo fill levels
`timescale 1ns/1ns
module twc_bus_model (
    input  wire logic              ref_clk_i,
    input  wire logic              rstn_i,
    input  wire twc_pkg::twc_ctl_t ctl_i,
    input  wire logic [2:0]        busy_i,
    input  wire logic              start_i,
    input  wire logic              bcast_i,
    input  wire logic [5:0]        tx_fill_i,
    input  wire logic [5:0]        rx_fill_i,
    output twc_pkg::twc_engine_t   eng_o,
    output logic      [5:0]        tx_level_o,
    output logic      [5:0]        rx_level_o
);
    logic busy_q;
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            eng_o      <= '0;
            tx_level_o <= 6'h00;
            rx_level_o <= 6'h00;
            busy_q     <= 1'b0;
        end else begin
            busy_q                   <= busy_i[0];
            eng_o.initiator_fsm_busy <= busy_i[0];
            eng_o.target_fsm_busy    <= busy_i[1];
            eng_o.bus_busy           <= busy_i[2];
            eng_o.start_seen         <= start_i;
            eng_o.broadcast_call     <= bcast_i;
            eng_o.xfer_done          <= busy_q & ~busy_i[0];
            eng_o.byte_done          <= busy_q & ~busy_i[0];
            // a flushed fifo holds nothing while the controller is off
            tx_level_o <= ctl_i.tx_flush ? 6'h00 : tx_fill_i;
            rx_level_o <= ctl_i.rx_flush ? 6'h00 : rx_fill_i;
        end
    end
endmodule : twc_bus_model

// ---- twc_ctrl.sv ----
// enable, status, flag clearing and interrupt logic of the controller
`timescale 1ns/1ns
module twc_ctrl (
    input  wire logic                     ref_clk_i,
    input  wire logic                     rstn_i,
    input  wire logic [31:0]              addr_i,
    input  wire logic [15:0]              wdata_i,
    input  wire logic                     wr_i,
    input  wire logic                     rd_i,
    output logic      [15:0]              rdata_o,
    input  wire twc_pkg::twc_engine_t     eng_i,
    input  wire logic [5:0]               tx_level_i,
    input  wire logic [5:0]               rx_level_i,
    output twc_pkg::twc_ctl_t             ctl_o,
    output logic                          irq_o
);
    // engine status arrives from a foreign domain: two stages
    twc_pkg::twc_engine_t eng_s1;
    twc_pkg::twc_engine_t eng;
    logic [5:0]           txl_s1;
    logic [5:0]           txl;
    logic [5:0]           rxl_s1;
    logic [5:0]           rxl;
    logic                 en_req;
    logic [1:0]           en_pipe;
    logic [15:0]          raw;
    logic [2:0]           irq_st;
    logic [2:0]           irq_mask;
    logic                 stop_tx;
    logic                 stop_rx;
    logic [15:0]          status;

    wire en_eff = en_pipe[1];
    wire sel_start = addr_i == twc_pkg::START_DETECT_CLEAR_OFS;
    wire sel_bcast = addr_i == twc_pkg::GENERAL_CALL_CLEAR_OFS;
    wire sel_en    = addr_i == twc_pkg::CONTROLLER_ENABLE_OFS;
    wire sel_st    = addr_i == twc_pkg::CONTROLLER_STATUS_OFS;
    wire sel_raw   = addr_i == twc_pkg::RAW_IRQ_FLAGS_OFS;
    wire sel_mask  = addr_i == twc_pkg::IRQ_MASK_OFS;
    wire sel_ist   = addr_i == twc_pkg::IRQ_STATUS_OFS;
    wire clr_start = rd_i && sel_start;
    wire clr_bcast = rd_i && sel_bcast;
    wire idle_now  = !eng.initiator_fsm_busy && !eng.target_fsm_busy
                     && !eng.bus_busy;
    wire any_busy  = !idle_now;
    // activity drops by itself only once disabled and the bus is quiet
    wire quiet_off = !en_eff && idle_now;
    wire sel_act   = addr_i == twc_pkg::ACTIVITY_CLEAR_OFS;
    wire clr_act   = (rd_i && sel_act && idle_now) || quiet_off;
    // bit 2 has no event source in this slice
    wire [2:0] ev  = {1'b0, eng.broadcast_call, eng.start_seen};

    always_comb begin
        status = 16'h0000;
        status[twc_pkg::ST_TARGET_BUSY] = eng.target_fsm_busy;
        status[twc_pkg::ST_INIT_BUSY]   = eng.initiator_fsm_busy;
        status[twc_pkg::ST_RX_FULL]     =
            rxl == 6'(twc_pkg::FIFO_DEPTH);
        status[twc_pkg::ST_RX_NONEMPTY] = rxl != 6'h00;
        status[twc_pkg::ST_TX_EMPTY]    = txl == 6'h00;
        status[twc_pkg::ST_TX_ROOM]     =
            txl != 6'(twc_pkg::FIFO_DEPTH);
        status[twc_pkg::ST_ACTIVITY]    = any_busy;
    end

    wire [15:0] next_rdata =
        sel_en   ? {15'h0000, en_req} :
        sel_st   ? status :
        sel_raw  ? raw :
        sel_mask ? {13'h0000, irq_mask} :
        sel_ist  ? {13'h0000, irq_st} :
        16'h0000; // clear registers and unmapped addresses read zero

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            eng_s1 <= '0;
            eng    <= '0;
            txl_s1 <= 6'h00;
            txl    <= 6'h00;
            rxl_s1 <= 6'h00;
            rxl    <= 6'h00;
        end else begin
            eng_s1 <= eng_i;
            eng    <= eng_s1;
            txl_s1 <= tx_level_i;
            txl    <= txl_s1;
            rxl_s1 <= rx_level_i;
            rxl    <= rxl_s1;
        end
    end

    // enable register and its two-cycle delayed effect
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            en_req  <= twc_pkg::ENABLE_RST[0];
            en_pipe <= 2'h0;
        end else begin
            if (wr_i && sel_en)
                en_req <= wdata_i[twc_pkg::EN_BIT];
            en_pipe <= {en_pipe[0], en_req};
        end
    end

    // raw flags: a set in the cycle of its clear wins
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            raw <= 16'h0000;
        end else begin
            raw[twc_pkg::START_SEEN_BIT] <= eng.start_seen ||
                (raw[twc_pkg::START_SEEN_BIT] && !clr_start);
            raw[twc_pkg::BCAST_BIT] <= eng.broadcast_call ||
                (raw[twc_pkg::BCAST_BIT] && !clr_bcast);
            raw[twc_pkg::ACT_BIT] <= any_busy ||
                (raw[twc_pkg::ACT_BIT] && !clr_act);
        end
    end

    // sticky block status, write one to clear, set wins
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_st   <= 3'h0;
            irq_mask <= twc_pkg::MASK_RST;
        end else begin
            if (wr_i && sel_mask)
                irq_mask <= wdata_i[2:0];
            // flags stay standing through disable until written one to clear
            irq_st <= ev | (irq_st & ~((wr_i && sel_ist) ? wdata_i[2:0]
                                                         : 3'h0));
        end
    end

    // disable handling while a transfer is underway
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stop_tx <= 1'b0;
            stop_rx <= 1'b0;
        end else begin
            stop_tx <= !en_eff && eng.initiator_fsm_busy;
            stop_rx <= !en_eff && eng.target_fsm_busy;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= 16'h0000;
            ctl_o   <= '0;
            irq_o   <= 1'b0;
        end else begin
            rdata_o <= rd_i ? next_rdata : 16'h0000;
            ctl_o.ctrl_en         <= en_eff;
            ctl_o.stop_after_xfer <= stop_tx;
            ctl_o.nack_stop       <= stop_rx;
            ctl_o.tx_flush        <= !en_eff;
            ctl_o.rx_flush        <= !en_eff;
            irq_o <= |(irq_st & irq_mask);
        end
    end

    // enable timing and controls
    a_en_delay: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        $rose(en_req) |-> ##2 en_eff)
        else $error("enable not effective after two cycles");

    a_dis_delay: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        $fell(en_req) |-> ##2 !en_eff)
        else $error("disable timing wrong");

    a_en_write: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        wr_i && sel_en |=> en_req == $past(wdata_i[0]))
        else $error("enable write not taken");

    a_en_out: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        en_eff |=> ctl_o.ctrl_en && !ctl_o.tx_flush)
        else $error("enabled controller still flushed");

    a_flush_out: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        !en_eff |=> ctl_o.tx_flush && ctl_o.rx_flush)
        else $error("fifos not flushed while disabled");

    a_stop_tx: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        !en_eff && eng.initiator_fsm_busy |=> ##1 ctl_o.stop_after_xfer)
        else $error("transmit stop not requested");

    a_stop_rx: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        !en_eff && eng.target_fsm_busy |=> ##1 ctl_o.nack_stop)
        else $error("receive stop not requested");

    // flag set and clear
    a_start_clr: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        clr_start && !eng.start_seen |=> !raw[10])
        else $error("start flag not cleared by read");

    a_bcast_clr: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        clr_bcast && !eng.broadcast_call |=> !raw[11])
        else $error("broadcast flag not cleared by read");

    a_set_wins: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        eng.start_seen |=> raw[10])
        else $error("start event lost");

    a_bcast_wins: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        eng.broadcast_call |=> raw[11])
        else $error("broadcast event lost");

    // activity flag
    a_act_set: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        any_busy |=> raw[8])
        else $error("activity flag not set");

    a_act_auto: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        quiet_off |=> !raw[8])
        else $error("activity flag not dropped when off");

    a_act_clr: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        rd_i && sel_act && idle_now |=> !raw[8])
        else $error("activity flag not cleared by read");

    // status and readback
    a_st_read: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        rd_i && sel_st |=> rdata_o[15:7] == 9'h000 &&
        rdata_o[2] == $past(txl == 6'h00))
        else $error("status readback wrong");

    a_rd_target: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        rd_i && sel_st |=> rdata_o[6] == $past(eng.target_fsm_busy))
        else $error("target busy readback wrong");

    a_rd_init: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        rd_i && sel_st |=> rdata_o[5] == $past(eng.initiator_fsm_busy))
        else $error("initiator busy readback wrong");

    a_rd_full: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        rd_i && sel_st |=> rdata_o[4] == ($past(rxl) == 6'h20))
        else $error("receive full readback wrong");

    a_rd_rxne: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        rd_i && sel_st |=> rdata_o[3] == ($past(rxl) != 6'h00))
        else $error("receive nonempty readback wrong");

    a_rd_room: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        rd_i && sel_st |=> rdata_o[1] == ($past(txl) != 6'h20))
        else $error("transmit room readback wrong");

    a_rd_act: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        rd_i && sel_st |=> rdata_o[0] == $past(any_busy))
        else $error("activity readback wrong");

    a_rx_full: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        rxl == 6'h20 |-> status[4] && status[3])
        else $error("receive full status wrong");

    a_rx_empty: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        rxl == 6'h00 |-> !status[3] && !status[4])
        else $error("receive empty status wrong");

    a_tx_room: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        txl == 6'h20 |-> !status[1] && !status[2])
        else $error("transmit room status wrong");

    a_tx_empty: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        txl == 6'h00 |-> status[2] && status[1])
        else $error("transmit empty status wrong");

    // reserved and idle read data
    a_rd_idle: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        !rd_i |=> rdata_o == 16'h0000)
        else $error("read data outside read cycle");

    a_en_rsvd: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        rd_i && sel_en |=> rdata_o[15:1] == 15'h0000)
        else $error("enable reserved bits not zero");

    a_clr_rd: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        rd_i && (sel_start || sel_bcast) |=> rdata_o == 16'h0000)
        else $error("clear register read not zero");

    // interrupt level
    a_irq_lvl: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        |(irq_st & irq_mask) |=> irq_o)
        else $error("interrupt not raised");

    a_irq_low: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        !(|(irq_st & irq_mask)) |=> !irq_o)
        else $error("interrupt raised with nothing pending");

    a_irq_keep: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        irq_st[0] && !(wr_i && sel_ist && wdata_i[0]) |=> irq_st[0])
        else $error("pending flag lost without clear");

    c_enable: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $rose(en_eff));
    c_disable_busy: cover property (@(posedge ref_clk_i)
        disable iff (!rstn_i) $fell(en_eff) && any_busy);
    c_start_clr: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
        raw[10] && clr_start);
    c_irq: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $rose(irq_o));
    c_act_clr: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
        raw[8] && quiet_off);
endmodule : twc_ctrl

// ---- twc_pkg.sv ----
// package for the two-wire controller enable and status slice
package twc_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 32;
    localparam int LVL_W = 6;

    // register byte addresses
    localparam logic [31:0] START_DETECT_CLEAR_OFS = 32'h50001464;
    localparam logic [31:0] GENERAL_CALL_CLEAR_OFS = 32'h50001468;
    localparam logic [31:0] CONTROLLER_ENABLE_OFS  = 32'h5000146C;
    localparam logic [31:0] CONTROLLER_STATUS_OFS  = 32'h50001470;
    localparam logic [31:0] ACTIVITY_CLEAR_OFS     = 32'h5000145C;
    localparam logic [31:0] RAW_IRQ_FLAGS_OFS      = 32'h50001480;
    localparam logic [31:0] IRQ_MASK_OFS           = 32'h50001484;
    localparam logic [31:0] IRQ_STATUS_OFS         = 32'h50001488;

    // raw flag positions
    localparam int START_SEEN_BIT = 10;
    localparam int BCAST_BIT      = 11;
    localparam int ACT_BIT        = 8;
    // status positions
    localparam int ST_TARGET_BUSY = 6;
    localparam int ST_INIT_BUSY   = 5;
    localparam int ST_RX_FULL     = 4;
    localparam int ST_RX_NONEMPTY = 3;
    localparam int ST_TX_EMPTY    = 2;
    localparam int ST_TX_ROOM     = 1;
    localparam int ST_ACTIVITY    = 0;
    localparam int EN_BIT         = 0;
    // block irq events: 0 start seen, 1 broadcast call, 2 has no source (tied low)
    localparam int IRQ_N = 3;

    localparam logic [15:0] ENABLE_RST = 16'h0000;
    localparam logic [15:0] STATUS_RST = 16'h0006;
    localparam logic [2:0]  MASK_RST   = 3'h0;
    // two controller-clock delay on enable changes
    localparam int EN_DELAY_CYC = 2;

    typedef struct packed {
        logic initiator_fsm_busy;
        logic target_fsm_busy;
        logic bus_busy;
        logic start_seen;
        logic broadcast_call;
        logic byte_done;
        logic xfer_done;
    } twc_engine_t;

    typedef struct packed {
        logic ctrl_en;
        logic stop_after_xfer;
        logic nack_stop;
        logic tx_flush;
        logic rx_flush;
    } twc_ctl_t;
endpackage : twc_pkg
